// [verilog/audio_clock_source_autoselect.sv]
// Notes on behaviour
// - in automatic mode every digital input is monitored for a valid signal
// - a valid input found in automatic mode replaces the crystal and is reported, unless it is aes with preferred input 3
// - loss of the followed reference in automatic mode moves to another valid input, aes excepted under preferred input 3, else to internal master
// - in automatic mode the preferred input is used whenever it carries a valid signal
// - otherwise the other inputs are tried in turn (only coax, then optical, with preferred input 3), else internal clock
// - each input reports no lock, lock or sync
// - each input reports its rate; unrecognised rate shows as no lock
// - optical port multiplexes channels at double and quad speed, leaving four or two
// - on double or quad speed the unavailable optical channels are withdrawn
// - while slaved the external rate holds and host rate requests are refused
// - rate of sync source unlike configured rate reports actual rate and flags mismatch
// - fixed internal mode never follows any input
module audio_clock_source_autoselect
  import clk_sel_pkg::*;
#(
  parameter int WINDOW_CYC = MEAS_WINDOW_CYC,
  parameter int CRYSTAL_DIV = 104
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // digital inputs: recovered frame clocks and carrier detect
  input wire logic [NUM_INPUTS-1:0] frame_clk_in,
  input wire logic [NUM_INPUTS-1:0] carrier_ok_in,
  // host configuration
  input wire logic [1:0] clock_mode,
  input wire logic [1:0] preferred_input,
  input wire logic [3:0] requested_rate,
  // selection result
  output logic [1:0] current_source,
  output logic slaved,
  output logic [3:0] current_rate,
  output logic rate_mismatch,
  output logic request_refused,
  // per input report
  output logic [2*NUM_INPUTS-1:0] input_status,
  output logic [4*NUM_INPUTS-1:0] input_rate,
  // optical multichannel
  output logic [1:0] speed_range,
  output logic [OPT_CHANNELS-1:0] opt_channel_enable,
  output logic [1:0] opt_mux_factor
);

  initial begin
    if (CRYSTAL_DIV < 2) $error("crystal divider too small");
  end

  logic [NUM_INPUTS-1:0] valid;
  logic [NUM_INPUTS-1:0] tick;
  logic [3:0] rate_w [NUM_INPUTS];
  logic [1:0] status_w [NUM_INPUTS];
  logic sel_tick;
  logic [15:0] xtal_cnt_reg;
  logic xtal_tick_reg;
  logic [1:0] src_next;
  logic [3:0] internal_rate_reg;
  logic [3:0] rate_next;
  logic [1:0] speed_next;

  // one monitor per input; all scanned every window
  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_mon
    input_monitor #(
      .WINDOW_CYC(WINDOW_CYC)
    ) u_mon (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .frame_clk(frame_clk_in[i]),
      .carrier_ok(carrier_ok_in[i]),
      .sel_tick(sel_tick),
      .valid(valid[i]),
      .rate(rate_w[i]),
      .status(status_w[i]),
      .tick(tick[i])
    );
  end

  // crystal frame tick stands in as reference while master
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      xtal_cnt_reg <= '0;
      xtal_tick_reg <= 1'b0;
    end else begin
      xtal_tick_reg <= (xtal_cnt_reg == 16'(CRYSTAL_DIV - 1));
      if (xtal_cnt_reg == 16'(CRYSTAL_DIV - 1)) xtal_cnt_reg <= '0;
      else xtal_cnt_reg <= xtal_cnt_reg + 16'h0001;
    end
  end

  assign sel_tick = (current_source == SRC_INTERNAL) ? xtal_tick_reg : tick[current_source];

  // source choice: preferred first, then round robin after it, else internal
  always_comb begin
    logic [1:0] cand;
    cand = 2'h0;
    src_next = SRC_INTERNAL;
    if (clock_mode == MODE_AUTO) begin
      if (preferred_input < 2'(NUM_INPUTS) && valid[preferred_input]) begin
        src_next = preferred_input;
      end else begin
        for (int k = NUM_INPUTS - 1; k >= 1; k--) begin
          cand = 2'((32'(preferred_input) + 32'(k)) % NUM_INPUTS);
          if (valid[cand]) src_next = cand;
        end
      end
      // nothing valid leaves src_next internal
    end
    // master and internal modes keep the crystal
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      current_source <= SRC_INTERNAL;
      slaved <= 1'b0;
    end else begin
      current_source <= src_next;
      // reference lost: src_next moves to another valid input, never aes with preferred input 3, else internal, taken on the next cycle
      slaved <= (src_next != SRC_INTERNAL);
    end
  end
  // in the choice above: only auto mode ever leaves the crystal

  // host rate request accepted only as master
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      internal_rate_reg <= RATE_48K;
      request_refused <= 1'b0;
    end else begin
      if (!slaved && requested_rate != RATE_NONE) internal_rate_reg <= requested_rate;
      request_refused <= slaved && requested_rate != current_rate;
    end
  end

  always_comb begin
    rate_next = slaved ? rate_w[current_source] : internal_rate_reg;
    if (rate_next >= RATE_128K) speed_next = SPEED_QUAD;
    else if (rate_next >= RATE_64K) speed_next = SPEED_DOUBLE;
    else speed_next = SPEED_SINGLE;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      current_rate <= RATE_48K;
      rate_mismatch <= 1'b0;
    end else begin
      current_rate <= rate_next;
      rate_mismatch <= slaved && rate_next != requested_rate;
    end
  end

  // optical sample multiplexing tracks the speed range
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      speed_range <= SPEED_SINGLE;
      opt_channel_enable <= OPT_EN_SINGLE;
      opt_mux_factor <= 2'h0;
    end else begin
      speed_range <= speed_next;
      case (speed_next)
        SPEED_DOUBLE: begin
          opt_channel_enable <= OPT_EN_DOUBLE;
          opt_mux_factor <= 2'h1;
        end
        SPEED_QUAD: begin
          opt_channel_enable <= OPT_EN_QUAD;
          opt_mux_factor <= 2'h2;
        end
        default: begin
          opt_channel_enable <= OPT_EN_SINGLE;
          opt_mux_factor <= 2'h0;
        end
      endcase
    end
  end

  // per input report
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      input_status <= '0;
      input_rate <= '0;
    end else begin
      for (int i = 0; i < NUM_INPUTS; i++) begin
        input_status[2*i +: 2] <= status_w[i];
        input_rate[4*i +: 4] <= rate_w[i];
      end
    end
  end

endmodule : audio_clock_source_autoselect

// [pkg/clk_sel_pkg.sv]
package clk_sel_pkg;

  // input indices
  localparam int NUM_INPUTS = 3;
  localparam logic [1:0] IN_AES = 2'h0;
  localparam logic [1:0] IN_COAX = 2'h1;
  localparam logic [1:0] IN_OPT = 2'h2;

  // clock source codes reported to the host
  localparam logic [1:0] SRC_INTERNAL = 2'h3;

  // clock mode requested by the host
  typedef enum logic [1:0] {
    MODE_MASTER = 2'b00,
    MODE_AUTO = 2'b01,
    MODE_INTERNAL = 2'b10
  } clock_mode_t;

  // per input report
  localparam logic [1:0] STAT_NO_LOCK = 2'h0;
  localparam logic [1:0] STAT_LOCK = 2'h1;
  localparam logic [1:0] STAT_SYNC = 2'h2;

  // rate codes
  localparam logic [3:0] RATE_NONE = 4'h0;
  localparam logic [3:0] RATE_32K = 4'h1;
  localparam logic [3:0] RATE_44K1 = 4'h2;
  localparam logic [3:0] RATE_48K = 4'h3;
  localparam logic [3:0] RATE_64K = 4'h4;
  localparam logic [3:0] RATE_88K2 = 4'h5;
  localparam logic [3:0] RATE_96K = 4'h6;
  localparam logic [3:0] RATE_128K = 4'h7;
  localparam logic [3:0] RATE_176K4 = 4'h8;
  localparam logic [3:0] RATE_192K = 4'h9;

  // speed range
  localparam logic [1:0] SPEED_SINGLE = 2'h0;
  localparam logic [1:0] SPEED_DOUBLE = 2'h1;
  localparam logic [1:0] SPEED_QUAD = 2'h2;

  // optical port channel enables
  localparam int OPT_CHANNELS = 8;
  localparam logic [7:0] OPT_EN_SINGLE = 8'hFF;
  localparam logic [7:0] OPT_EN_DOUBLE = 8'h0F;
  localparam logic [7:0] OPT_EN_QUAD = 8'h03;

  // timing
  localparam int CLK_SYS_HZ = 10_000_000;
  localparam int MEAS_WINDOW_US = 100;
  localparam int MEAS_WINDOW_CYC = MEAS_WINDOW_US * (CLK_SYS_HZ / 1_000_000);
  localparam int SCAN_DWELL_US = 2;
  localparam int SCAN_DWELL_CYC = SCAN_DWELL_US * (CLK_SYS_HZ / 1_000_000);

  // phase tolerance in system cycles between an input frame edge and the selected clock
  localparam int PHASE_TOL_CYC = 2;

  // validity bound: minimum frame edge count per measurement window
  localparam int EDGES_MIN_VALID = 2;

endpackage : clk_sel_pkg

// [verilog/edge_sync.sv]
module edge_sync
  import clk_sel_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // asynchronous input
  input wire logic async_in,
  // synchronised outputs
  output logic level_out,
  output logic rise_out
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_out <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
        rise_out <= s3_reg & ~level_out;
      end else begin
        rise_out <= 1'b0;
      end
    end
  end

endmodule : edge_sync

// [verilog/input_monitor.sv]
module input_monitor
  import clk_sel_pkg::*;
#(
  parameter int WINDOW_CYC = MEAS_WINDOW_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // recovered frame clock and carrier lock from the receiver
  input wire logic frame_clk,
  input wire logic carrier_ok,
  // frame tick of the currently selected clock
  input wire logic sel_tick,
  // results
  output logic valid,
  output logic [3:0] rate,
  output logic [1:0] status,
  output logic tick
);

  initial begin
    if (WINDOW_CYC < 16) $error("window too short");
  end

  logic ok_lvl;
  logic edge_rise;
  logic [31:0] win_cnt_reg;
  logic [11:0] edge_cnt_reg;
  logic [7:0] since_sel_reg;
  logic coherent_reg;

  edge_sync u_frame (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(frame_clk),
    .level_out(),
    .rise_out(edge_rise)
  );

  edge_sync u_ok (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in(carrier_ok),
    .level_out(ok_lvl),
    .rise_out()
  );

  assign tick = edge_rise;

  // coarse rate: edges per window scaled to kHz
  function automatic logic [3:0] classify(input logic [11:0] n);
    logic [31:0] khz;
    khz = (32'(n) * 32'(CLK_SYS_HZ / 1000)) / 32'(WINDOW_CYC);
    if (khz < 28) classify = RATE_NONE;
    else if (khz < 38) classify = RATE_32K;
    else if (khz < 46) classify = RATE_44K1;
    else if (khz < 56) classify = RATE_48K;
    else if (khz < 76) classify = RATE_64K;
    else if (khz < 92) classify = RATE_88K2;
    else if (khz < 112) classify = RATE_96K;
    else if (khz < 152) classify = RATE_128K;
    else if (khz < 184) classify = RATE_176K4;
    else if (khz < 210) classify = RATE_192K;
    else classify = RATE_NONE;
  endfunction : classify

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt_reg <= '0;
      edge_cnt_reg <= '0;
      since_sel_reg <= '0;
      coherent_reg <= 1'b1;
      rate <= RATE_NONE;
      valid <= 1'b0;
      status <= STAT_NO_LOCK;
    end else begin
      if (sel_tick) since_sel_reg <= '0;
      else if (since_sel_reg != 8'hFF) since_sel_reg <= since_sel_reg + 8'h01;
      if (win_cnt_reg == 32'(WINDOW_CYC - 1)) begin
        win_cnt_reg <= '0;
        // an edge on the closing cycle opens the next window instead of being lost
        edge_cnt_reg <= edge_rise ? 12'h001 : 12'h000;
        coherent_reg <= !(edge_rise && since_sel_reg > 8'(PHASE_TOL_CYC) && !sel_tick);
        rate <= ok_lvl ? classify(edge_cnt_reg) : RATE_NONE;
        // no recognised rate reads as no lock
        valid <= ok_lvl && (edge_cnt_reg >= 12'(EDGES_MIN_VALID))
                 && (classify(edge_cnt_reg) != RATE_NONE);
        if (!(ok_lvl && classify(edge_cnt_reg) != RATE_NONE)) status <= STAT_NO_LOCK;
        else if (coherent_reg) status <= STAT_SYNC;
        else status <= STAT_LOCK;
      end else begin
        win_cnt_reg <= win_cnt_reg + 32'h1;
        if (edge_rise) begin
          edge_cnt_reg <= edge_cnt_reg + 12'h001;
          // phase coherence: each input frame edge must land near a selected-clock edge
          if (since_sel_reg > 8'(PHASE_TOL_CYC) && !sel_tick) coherent_reg <= 1'b0;
        end
      end
    end
  end

endmodule : input_monitor

// [verif/clk_sel_properties.sv]
module clk_sel_checker
  import clk_sel_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // host side
  input wire logic [1:0] clock_mode,
  input wire logic [1:0] preferred_input,
  input wire logic [3:0] requested_rate,
  // results
  input wire logic [1:0] current_source,
  input wire logic slaved,
  input wire logic [3:0] current_rate,
  input wire logic rate_mismatch,
  input wire logic request_refused,
  input wire logic [5:0] input_status,
  input wire logic [11:0] input_rate,
  input wire logic [7:0] opt_channel_enable
);
  logic [7:0] en_exp;
  logic rep_ok;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  assign en_exp = current_rate >= RATE_128K ? OPT_EN_QUAD :
    current_rate >= RATE_64K ? OPT_EN_DOUBLE : OPT_EN_SINGLE;
  always_comb begin
    rep_ok = 1'b1;
    for (int i = 0; i < 3; i++) begin
      if (input_status[2*i+:2] == 2'h3 ||
          (input_rate[4*i+:4] == RATE_NONE && input_status[2*i+:2] != STAT_NO_LOCK)) begin
        rep_ok = 1'b0;
      end
    end
  end
  property p_slave_src;
    slaved == (current_source != SRC_INTERNAL);
  endproperty
  a_slave_src: assert property (p_slave_src) else $error("slaved flag wrong");
  property p_internal;
    (clock_mode != MODE_AUTO)[*3] |-> current_source == SRC_INTERNAL && !slaved;
  endproperty
  a_internal: assert property (p_internal) else $error("input followed");
  property p_fallback;
    slaved && input_status[2*current_source+:2] == STAT_NO_LOCK |->
      ##[1:3] (current_source == SRC_INTERNAL || input_status[2*current_source+:2] != 2'h0);
  endproperty
  a_fallback: assert property (p_fallback) else $error("lost source kept");
  property p_pref;
    (clock_mode == MODE_AUTO && preferred_input != 2'h3 &&
      input_status[2*preferred_input+:2] != STAT_NO_LOCK)[*4] |-> current_source == preferred_input;
  endproperty
  a_pref: assert property (p_pref) else $error("preferred not used");
  property p_refuse;
    (slaved && requested_rate != current_rate)[*2] |-> request_refused;
  endproperty
  a_refuse: assert property (p_refuse) else $error("request not refused");
  property p_mismatch;
    (slaved && requested_rate != current_rate)[*2] |-> rate_mismatch;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch not flagged");
  property p_opt_en;
    $stable(current_rate)[*3] |-> opt_channel_enable == en_exp;
  endproperty
  a_opt_en: assert property (p_opt_en) else $error("optical enables wrong");
  property p_report;
    rep_ok;
  endproperty
  a_report: assert property (p_report) else $error("input report wrong");
endmodule : clk_sel_checker

bind audio_clock_source_autoselect clk_sel_checker u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .clock_mode(clock_mode),
  .preferred_input(preferred_input), .requested_rate(requested_rate),
  .current_source(current_source), .slaved(slaved), .current_rate(current_rate),
  .rate_mismatch(rate_mismatch), .request_refused(request_refused),
  .input_status(input_status), .input_rate(input_rate),
  .opt_channel_enable(opt_channel_enable)
);

// [verif/audio_source_model.sv]
module audio_source_model #(
  parameter int HALF_NS = 400
) (
  // bench control
  input wire logic src_on,
  // receiver side
  output logic frame_clk,
  output logic carrier_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  // clock stands low when off, so a lost source cannot look alive
  initial frame_clk = 1'b0;
  always begin
    #(HALF_NS);
    frame_clk = src_on ? ~frame_clk : 1'b0;
  end
  assign carrier_ok = src_on;
endmodule : audio_source_model

// [verif/testbench.sv]
module testbench
  import clk_sel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WIN = 2000;
  localparam int SETTLE = 4 * WIN;
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] pref;
    logic [2:0] on;
    logic [1:0] src;
  } row_t;
  row_t rows [9] = '{'{MODE_AUTO, 2'h0, 3'b001, IN_AES}, '{MODE_AUTO, 2'h0, 3'b110, IN_COAX},
    '{MODE_AUTO, 2'h1, 3'b101, IN_OPT}, '{MODE_AUTO, 2'h2, 3'b011, IN_AES},
    '{MODE_AUTO, 2'h3, 3'b110, IN_COAX}, '{MODE_AUTO, 2'h1, 3'b000, SRC_INTERNAL},
    '{MODE_INTERNAL, 2'h0, 3'b111, SRC_INTERNAL}, '{MODE_MASTER, 2'h0, 3'b111, SRC_INTERNAL},
    '{MODE_AUTO, 2'h2, 3'b111, IN_OPT}};
  logic [3:0] rq [3] = '{RATE_48K, RATE_96K, RATE_192K};
  logic [7:0] en [3] = '{OPT_EN_SINGLE, OPT_EN_DOUBLE, OPT_EN_QUAD};
  logic [3:0] src_rate [3] = '{RATE_192K, RATE_96K, RATE_32K};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] src_on = 3'h0;
  logic [2:0] frame_clk_in;
  logic [2:0] carrier_ok_in;
  logic [1:0] clock_mode = 2'h0;
  logic [1:0] preferred_input = 2'h0;
  logic [3:0] requested_rate = RATE_48K;
  logic [1:0] current_source;
  logic slaved;
  logic [3:0] current_rate;
  logic [3:0] held;
  logic rate_mismatch;
  logic request_refused;
  logic [5:0] input_status;
  logic [11:0] input_rate;
  logic [1:0] speed_range;
  logic [7:0] opt_channel_enable;
  logic [1:0] opt_mux_factor;
  int fails = 0;
  int n_tests = 0;

  always #50 clk_sys = ~clk_sys;

  // three sources at unlike rates: 192k, 96k and 32k frame clocks
  audio_source_model #(.HALF_NS(2604)) src_aes (.src_on(src_on[0]),
    .frame_clk(frame_clk_in[0]), .carrier_ok(carrier_ok_in[0]));
  audio_source_model #(.HALF_NS(5208)) src_coax (.src_on(src_on[1]),
    .frame_clk(frame_clk_in[1]), .carrier_ok(carrier_ok_in[1]));
  audio_source_model #(.HALF_NS(15625)) src_opt (.src_on(src_on[2]),
    .frame_clk(frame_clk_in[2]), .carrier_ok(carrier_ok_in[2]));

  audio_clock_source_autoselect #(.WINDOW_CYC(WIN)) DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .frame_clk_in(frame_clk_in),
    .carrier_ok_in(carrier_ok_in), .clock_mode(clock_mode), .preferred_input(preferred_input),
    .requested_rate(requested_rate), .current_source(current_source), .slaved(slaved),
    .current_rate(current_rate), .rate_mismatch(rate_mismatch),
    .request_refused(request_refused), .input_status(input_status), .input_rate(input_rate),
    .speed_range(speed_range), .opt_channel_enable(opt_channel_enable),
    .opt_mux_factor(opt_mux_factor));

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t %s", $time, what);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  task automatic complete_run;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    #9_000_000;
    fails++;
    complete_run();
  end

  initial begin
    step(3);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      clock_mode = rows[i].mode;
      preferred_input = rows[i].pref;
      src_on = rows[i].on;
      step(SETTLE);
      chk(current_source, rows[i].src, "source");
      chk(slaved, rows[i].src != SRC_INTERNAL, "slaved");
      for (int k = 0; k < 3; k++) begin
        chk(input_status[2*k+:2] == STAT_NO_LOCK, !rows[i].on[k], "lock");
        chk(input_rate[4*k+:4] == RATE_NONE, !rows[i].on[k], "rate");
        if (rows[i].on[k]) begin
          chk(input_rate[4*k+:4], src_rate[k], "rate code");
        end
      end
      if (rows[i].src != SRC_INTERNAL) begin
        chk(input_status[2*rows[i].src+:2], STAT_SYNC, "sync");
        chk(current_rate, src_rate[rows[i].src], "slave rate");
      end
      if (rows[i].mode == MODE_INTERNAL) begin
        // every other aes edge falls midway between crystal ticks, so it cannot be in sync
        chk(input_status[1:0], STAT_LOCK, "lock only");
      end
      $display("row %0d done", i);
    end
    // slaved: a foreign rate request must bounce off
    held = current_rate;
    requested_rate = (held == RATE_32K) ? RATE_192K : RATE_32K;
    step(6);
    chk(request_refused, 1'b1, "refuse");
    chk(rate_mismatch, 1'b1, "mismatch");
    chk(current_rate, held, "rate held");
    requested_rate = held;
    step(6);
    chk({request_refused, rate_mismatch}, 2'h0, "match");
    $display("slave rate test done");
    // master: the host rate is taken and the optical port follows
    clock_mode = MODE_MASTER;
    for (int k = 0; k < 3; k++) begin
      requested_rate = rq[k];
      step(8);
      chk(current_rate, rq[k], "master rate");
      chk(request_refused, 1'b0, "no refuse");
      chk(opt_channel_enable, en[k], "opt en");
      chk(speed_range, 12'(k), "speed");
      chk(opt_mux_factor, 12'(k), "mux");
    end
    $display("speed test done");
    // reset in mid-run must restore the idle report
    rst_n = 1'b0;
    step(2);
    chk({current_source, slaved, current_rate}, {SRC_INTERNAL, 1'b0, RATE_48K}, "rst sel");
    chk({input_status, opt_channel_enable}, {6'h00, 8'hFF}, "rst rep");
    rst_n = 1'b1;
    step(2);
    chk({current_source, slaved}, {SRC_INTERNAL, 1'b0}, "rel sel");
    chk(current_rate, RATE_192K, "rel rate");
    $display("reset test done");
    complete_run();
  end
endmodule : testbench
